// [common/isc_pkg.sv]
// Function
// - Interrupt control bit 22 turns interrupt vector prefetch on or off.
// - Chaining happens only while chain_enable, interrupt control bit 21, is set.
// - Prologue lowers stack by field words for 4..31, by 12 bytes for 0..3.
// - With bit 15 set, prologue and chaining clear base mode, error, exception levels.
// - Automatic prologue runs only while auto_prologue_enable, bit 14, is set.
// - Bit 13 keeps current set stack register, else copies it from previous set.
// - Spacing codes 0,1,2,4,8,16 give 0,32,64,128,256,512 bytes between vectors.
// - Unimplemented bits of all three registers read as zero.
// - Exceptions and non-vectored interrupts use exception set; external vectored use external.
// - Highest set field is read-only and reports the top implemented set number.
// - Controller supplies a set number per request; it is latched and used.
// - Kernel entry on non-vectored exceptions uses the exception shadow set.
// - Entry copies current set to previous; return with error level and boot vector clear restores it.
// - Error-setting exceptions, debug entry, or entry at raised level leave sets unchanged.
// - Current set is read-only, changes on entry and is restored on return.
// - Return does not restore current set while error level or boot vector is set.
// - Software changes current set only through previous set plus exception return.
// - Exception level sets on any exception except reset, soft reset and NMI.
// - Error level sets on reset, soft reset, NMI and cache error exceptions.
package isc_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_INT_CTRL   = 12'h000;
  localparam logic [11:0] OFF_SET_CTRL   = 12'h004;
  localparam logic [11:0] OFF_LEVEL_STAT = 12'h008;

  // Interrupt control fields
  localparam int ICTL_PREFETCH_BIT = 22;
  localparam int ICTL_CHAIN_BIT    = 21;
  localparam int ICTL_STACK_DECREMENT_WORDS_LSB   = 16;
  localparam int ICTL_CLRLVL_BIT   = 15;
  localparam int ICTL_PROLOGUE_BIT = 14;
  localparam int ICTL_KSTACK_BIT   = 13;
  localparam int ICTL_SPACING_LSB  = 5;
  localparam logic [31:0] ICTL_WMASK = 32'h007fe3e0;
  localparam logic [31:0] ICTL_RESET = 32'h00000000;

  // Shadow set control fields
  localparam int SRS_HIGHEST_LSB  = 26;
  localparam int SRS_EXTERNAL_LSB = 18;
  localparam int SRS_EXCEPT_LSB   = 12;
  localparam int SRS_PREVIOUS_LSB = 6;
  localparam int SRS_CURRENT_LSB  = 0;
  localparam logic [3:0] HIGHEST_SET = 4'h1;
  localparam logic [3:0] SET_RESET   = 4'h0;

  // Level status fields
  localparam int LVL_BOOT_BIT  = 22;
  localparam int LVL_BASE_BIT  = 4;
  localparam int LVL_ERROR_BIT = 2;
  localparam int LVL_EXCPT_BIT = 1;
  localparam logic LVL_BOOT_RESET  = 1'b1;
  localparam logic LVL_ERROR_RESET = 1'b1;

  // Prologue stack decrement
  localparam logic [4:0] STACK_DECREMENT_WORDS_MIN_WORDS = 5'h04;
  localparam logic [6:0] STACK_DECREMENT_WORDS_LOW_BYTES = 7'h0c;

  typedef enum logic [2:0] {
    ISC_EXC_GENERAL   = 3'b000,
    ISC_EXC_RESET     = 3'b001,
    ISC_EXC_SOFT      = 3'b010,
    ISC_EXC_NMI       = 3'b011,
    ISC_EXC_CACHE_ERR = 3'b100
  } isc_exc_kind_e;

  typedef struct packed {
    logic          take;
    logic          is_interrupt;
    isc_exc_kind_e kind;
  } isc_exc_evt_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] shadow_set;
  } isc_eic_req_s;

endpackage : isc_pkg

// [hdl/isc_shadow_ctrl.sv]
`timescale 1ns/1ps
module isc_shadow_ctrl (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Pipeline events
  input  wire isc_pkg::isc_exc_evt_s exc_evt,
  input  wire logic                  debug_entry,
  input  wire logic                  vector_int_flag,
  input  wire logic                  external_ctrl_mode_flag,
  input  wire logic                  exception_return_instr,
  input  wire logic                  chained_return_instr,
  input  wire logic                  prologue_req,
  // External interrupt controller
  input  wire isc_pkg::isc_eic_req_s eic_req,
  // Core controls
  output logic                       vector_prefetch_enable,
  output logic [9:0]                 vector_spacing_bytes,
  output logic                       chain_taken,
  output logic                       prologue_taken,
  output logic [6:0]                 stack_decrement_bytes,
  output logic                       copy_stack_from_prev,
  output logic [3:0]                 prev_set_sel,
  output logic [3:0]                 gpr_bank_sel,
  output logic                       error_level_flag,
  output logic                       exception_level_flag,
  output logic                       base_mode_field
);

  logic [31:0] ictl_reg;
  logic [31:0] ictl_next;
  logic [3:0]  ess_reg;
  logic [3:0]  ess_next;
  logic [3:0]  pss_reg;
  logic [3:0]  pss_next;
  logic [3:0]  css_reg;
  logic [3:0]  css_next;
  logic [3:0]  eic_reg;
  logic        boot_reg;
  logic        boot_next;
  logic        base_reg;
  logic        base_next;
  logic        erl_reg;
  logic        erl_next;
  logic        exl_reg;
  logic        exl_next;
  logic [9:0]  spacing_reg;
  logic        chain_reg;
  logic        prologue_reg;
  logic [6:0]  stack_decrement_words_reg;
  logic        copy_sp_reg;
  logic [3:0]  prev_sel_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // Reserved spacing codes map to zero spacing; behaviour is undefined anyway
  function automatic logic [9:0] spacing_decode(input logic [4:0] code);
    case (code)
      5'h00:   spacing_decode = 10'h000;
      5'h01:   spacing_decode = 10'h020;
      5'h02:   spacing_decode = 10'h040;
      5'h04:   spacing_decode = 10'h080;
      5'h08:   spacing_decode = 10'h100;
      5'h10:   spacing_decode = 10'h200;
      default: spacing_decode = 10'h000;
    endcase
  endfunction : spacing_decode

  // Register access decode
  wire        setup_ph   = psel & ~penable;
  wire        wr_access  = psel & penable & pwrite;
  wire        hit_ictl   = reg_hit(paddr, isc_pkg::OFF_INT_CTRL);
  wire        hit_srs    = reg_hit(paddr, isc_pkg::OFF_SET_CTRL);
  wire        hit_lvl    = reg_hit(paddr, isc_pkg::OFF_LEVEL_STAT);
  wire        mapped     = hit_ictl | hit_srs | hit_lvl;
  wire        wr_ictl    = wr_access & hit_ictl;
  wire        wr_srs     = wr_access & hit_srs;
  wire        wr_lvl     = wr_access & hit_lvl;

  // Interrupt control fields
  wire        f_chain    = ictl_reg[isc_pkg::ICTL_CHAIN_BIT];
  wire [4:0]  f_stack_decrement_words   = ictl_reg[isc_pkg::ICTL_STACK_DECREMENT_WORDS_LSB +: 5];
  wire        f_clrlvl   = ictl_reg[isc_pkg::ICTL_CLRLVL_BIT];
  wire        f_prologue = ictl_reg[isc_pkg::ICTL_PROLOGUE_BIT];
  wire        f_kstack   = ictl_reg[isc_pkg::ICTL_KSTACK_BIT];
  wire [4:0]  f_spacing  = ictl_reg[isc_pkg::ICTL_SPACING_LSB +: 5];

  // Exception entry classification
  wire        exc_sets_erl = exc_evt.take & (exc_evt.kind != isc_pkg::ISC_EXC_GENERAL);
  wire        exc_sets_exl = exc_evt.take &
                             (exc_evt.kind != isc_pkg::ISC_EXC_RESET) &
                             (exc_evt.kind != isc_pkg::ISC_EXC_SOFT) &
                             (exc_evt.kind != isc_pkg::ISC_EXC_NMI);
  // Debug entry is a separate strobe and never touches the sets
  wire        set_update = exc_evt.take & ~exc_sets_erl & ~exl_reg & ~boot_reg
                           & ~erl_reg & ~debug_entry;
  wire        use_eic    = exc_evt.is_interrupt & vector_int_flag
                           & external_ctrl_mode_flag;
  wire [3:0]  entry_set  = use_eic ? eic_reg : ess_reg;
  wire        ret_restore = exception_return_instr & ~erl_reg & ~boot_reg;
  wire        do_prologue = prologue_req & f_prologue;
  wire        do_chain    = chained_return_instr & f_chain;
  wire        lvl_clear   = (do_prologue | do_chain) & f_clrlvl;
  wire [6:0]  stack_decrement_words_bytes = (f_stack_decrement_words < isc_pkg::STACK_DECREMENT_WORDS_MIN_WORDS) ?
                             isc_pkg::STACK_DECREMENT_WORDS_LOW_BYTES : {f_stack_decrement_words, 2'b00};

  // Read data, unimplemented bits as zero
  wire [31:0] rd_ictl = ictl_reg & isc_pkg::ICTL_WMASK;
  wire [31:0] rd_srs  = (32'h00000000
                        | ({28'h0000000, isc_pkg::HIGHEST_SET} << isc_pkg::SRS_HIGHEST_LSB)
                        | ({28'h0000000, eic_reg} << isc_pkg::SRS_EXTERNAL_LSB)
                        | ({28'h0000000, ess_reg} << isc_pkg::SRS_EXCEPT_LSB)
                        | ({28'h0000000, pss_reg} << isc_pkg::SRS_PREVIOUS_LSB)
                        | ({28'h0000000, css_reg} << isc_pkg::SRS_CURRENT_LSB));
  wire [31:0] rd_lvl  = (32'h00000000
                        | ({31'h00000000, boot_reg} << isc_pkg::LVL_BOOT_BIT)
                        | ({31'h00000000, base_reg} << isc_pkg::LVL_BASE_BIT)
                        | ({31'h00000000, erl_reg} << isc_pkg::LVL_ERROR_BIT)
                        | ({31'h00000000, exl_reg} << isc_pkg::LVL_EXCPT_BIT));
  wire [31:0] rd_mux  = hit_ictl ? rd_ictl :
                        hit_srs  ? rd_srs  :
                        hit_lvl  ? rd_lvl  : 32'h00000000;

  // Next values of software-visible state
  always_comb begin
    ictl_next = wr_ictl ? (pwdata & isc_pkg::ICTL_WMASK) : ictl_reg;
    ess_next  = wr_srs ? pwdata[isc_pkg::SRS_EXCEPT_LSB +: 4] : ess_reg;
    pss_next  = wr_srs ? pwdata[isc_pkg::SRS_PREVIOUS_LSB +: 4] : pss_reg;
    css_next  = css_reg;
    if (set_update) begin
      pss_next = css_reg;
      css_next = entry_set;
    end else if (ret_restore) begin
      css_next = pss_reg;
    end
    boot_next = wr_lvl ? pwdata[isc_pkg::LVL_BOOT_BIT] : boot_reg;
    base_next = wr_lvl ? pwdata[isc_pkg::LVL_BASE_BIT] : base_reg;
    erl_next  = wr_lvl ? pwdata[isc_pkg::LVL_ERROR_BIT] : erl_reg;
    exl_next  = wr_lvl ? pwdata[isc_pkg::LVL_EXCPT_BIT] : exl_reg;
    if (lvl_clear) begin
      base_next = 1'b0;
      erl_next  = 1'b0;
      exl_next  = 1'b0;
    end
    // Hardware set beats any clear in the same cycle
    if (exc_sets_erl) begin
      erl_next = 1'b1;
    end
    if (exc_sets_exl) begin
      exl_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ictl_reg <= isc_pkg::ICTL_RESET;
      ess_reg  <= isc_pkg::SET_RESET;
      pss_reg  <= isc_pkg::SET_RESET;
      css_reg  <= isc_pkg::SET_RESET;
    end else begin
      ictl_reg <= ictl_next;
      ess_reg  <= ess_next;
      pss_reg  <= pss_next;
      css_reg  <= css_next;
    end
  end

  // Controller set number is captured with each request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eic_reg <= isc_pkg::SET_RESET;
    end else if (eic_req.valid) begin
      eic_reg <= eic_req.shadow_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= isc_pkg::LVL_BOOT_RESET;
      base_reg <= 1'b0;
      erl_reg  <= isc_pkg::LVL_ERROR_RESET;
      exl_reg  <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      base_reg <= base_next;
      erl_reg  <= erl_next;
      exl_reg  <= exl_next;
    end
  end

  // Prologue and chaining strobes to the pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_reg    <= 1'b0;
      prologue_reg <= 1'b0;
      stack_decrement_words_reg   <= 7'h00;
      copy_sp_reg  <= 1'b0;
      prev_sel_reg <= isc_pkg::SET_RESET;
    end else begin
      chain_reg    <= do_chain;
      prologue_reg <= do_prologue;
      stack_decrement_words_reg   <= do_prologue ? stack_decrement_words_bytes : 7'h00;
      copy_sp_reg  <= do_prologue & ~f_kstack;
      prev_sel_reg <= pss_reg;
    end
  end

  // Spacing is decoded once per clock so the vector adder sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spacing_reg <= 10'h000;
    end else begin
      spacing_reg <= spacing_decode(f_spacing);
    end
  end

  // Zero-wait slave: read data is taken in setup, ready stands high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup_ph) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= ~mapped;
      end
    end
  end

  assign pready                 = pready_reg;
  assign prdata                 = prdata_reg;
  assign pslverr                = pslverr_reg;
  assign vector_prefetch_enable = ictl_reg[isc_pkg::ICTL_PREFETCH_BIT];
  assign vector_spacing_bytes   = spacing_reg;
  assign chain_taken            = chain_reg;
  assign prologue_taken         = prologue_reg;
  assign stack_decrement_bytes  = stack_decrement_words_reg;
  assign copy_stack_from_prev   = copy_sp_reg;
  assign prev_set_sel           = prev_sel_reg;
  assign gpr_bank_sel           = css_reg;
  assign error_level_flag       = erl_reg;
  assign exception_level_flag   = exl_reg;
  assign base_mode_field        = base_reg;

endmodule : isc_shadow_ctrl

// [tb/isc_shadow_ctrl_sva.sv]
`timescale 1ns/1ps
module isc_shadow_ctrl_chk (
  // Clock, reset and APB
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  // Events
  input wire isc_pkg::isc_exc_evt_s exc_evt,
  input wire logic                  debug_entry,
  input wire logic                  exception_return_instr,
  input wire logic                  chained_return_instr,
  input wire logic                  prologue_req,
  // Core controls
  input wire logic                  vector_prefetch_enable,
  input wire logic [9:0]            vector_spacing_bytes,
  input wire logic                  chain_taken,
  input wire logic                  prologue_taken,
  input wire logic [6:0]            stack_decrement_bytes,
  input wire logic                  copy_stack_from_prev,
  input wire logic [3:0]            gpr_bank_sel,
  input wire logic                  error_level_flag,
  input wire logic                  exception_level_flag,
  input wire logic                  base_mode_field
);
  logic [31:0] ictl_q;
  logic [9:0]  sp_q;
  wire         wr_ictl = psel && penable && pwrite && paddr == 12'h000;
  wire [4:0]   dec     = ictl_q[20:16];
  wire [6:0]   dec_b   = (dec < 5'h04) ? 7'h0c : {dec, 2'b00};
  wire [4:0]   vs      = ictl_q[9:5];
  wire [9:0]   sp_w    = (vs == 5'h01) ? 10'h020 : (vs == 5'h02) ? 10'h040 :
                         (vs == 5'h04) ? 10'h080 : (vs == 5'h08) ? 10'h100 :
                         (vs == 5'h10) ? 10'h200 : 10'h000;
  wire         gen     = exc_evt.kind == isc_pkg::ISC_EXC_GENERAL;
  // Mirror of the control word so gating can be judged from the ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ictl_q <= 32'h0;
      sp_q   <= 10'h0;
    end else begin
      if (wr_ictl) ictl_q <= pwdata & isc_pkg::ICTL_WMASK;
      sp_q <= sp_w;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  prefetch_bit_a: assert property (
    wr_ictl |=> vector_prefetch_enable == $past(pwdata[22])) else $error("prefetch mismatch");
  chain_gate_a: assert property (
    chained_return_instr |=> chain_taken == $past(ictl_q[21])) else $error("chain gate");
  stack_dec_a: assert property (
    prologue_req && ictl_q[14] |=> prologue_taken && stack_decrement_bytes == $past(dec_b))
    else $error("stack decrement");
  prologue_off_a: assert property (
    prologue_req && !ictl_q[14] |=> !prologue_taken) else $error("prologue while off");
  kstack_sel_a: assert property (
    prologue_req && ictl_q[14] |=> copy_stack_from_prev == !$past(ictl_q[13]))
    else $error("stack copy select");
  clr_levels_a: assert property (
    chained_return_instr && ictl_q[21] && ictl_q[15] && !exc_evt.take
    |=> !error_level_flag && !exception_level_flag && !base_mode_field) else $error("no clear");
  spacing_val_a: assert property (
    vector_spacing_bytes == sp_q) else $error("spacing decode");
  exl_set_a: assert property (
    exc_evt.take && gen |=> exception_level_flag) else $error("exception level not set");
  erl_set_a: assert property (
    exc_evt.take && !gen |=> error_level_flag) else $error("error level not set");
  keep_sets_a: assert property (
    exc_evt.take && (exception_level_flag || error_level_flag || debug_entry || !gen)
    |=> $stable(gpr_bank_sel)) else $error("set changed on blocked entry");
  no_restore_a: assert property (
    exception_return_instr && error_level_flag |=> $stable(gpr_bank_sel))
    else $error("restore at error level");
endmodule : isc_shadow_ctrl_chk
bind isc_shadow_ctrl isc_shadow_ctrl_chk chk (.*);

// [tb/isc_eic_model.sv]
`timescale 1ns/1ps
module isc_eic_model (
  // Clock
  input wire logic              pclk,
  // Request to the core
  output isc_pkg::isc_eic_req_s eic_req
);
  initial eic_req = '0;
  task automatic send(input logic [3:0] set);
    logic [3:0] s;
    // Clipped, so the model never names an unimplemented set
    s = (set > isc_pkg::HIGHEST_SET) ? isc_pkg::HIGHEST_SET : set;
    @(posedge pclk);
    eic_req <= '{valid: 1'b1, shadow_set: s};
    @(posedge pclk);
    // Released lines do not keep the last number
    eic_req <= '{valid: 1'b0, shadow_set: ~s};
  endtask : send
endmodule : isc_eic_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  isc_pkg::isc_exc_evt_s exc_evt;
  isc_pkg::isc_eic_req_s eic_req;
  logic debug_entry, vector_int_flag, external_ctrl_mode_flag;
  logic exception_return_instr, chained_return_instr, prologue_req;
  logic vector_prefetch_enable, chain_taken, prologue_taken, copy_stack_from_prev;
  logic error_level_flag, exception_level_flag, base_mode_field;
  logic [9:0] vector_spacing_bytes;
  logic [6:0] stack_decrement_bytes;
  logic [3:0] prev_set_sel, gpr_bank_sel;
  int fail_count, checks;
  isc_shadow_ctrl dut (.*);
  isc_eic_model eic (.pclk(pclk), .eic_req(eic_req));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      fail_count++;
      test_done();
    end
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic ev(input logic i, input isc_pkg::isc_exc_kind_e k, input logic dbg);
    @(posedge pclk);
    exc_evt <= '{take: 1'b1, is_interrupt: i, kind: k};
    debug_entry <= dbg;
    @(posedge pclk);
    exc_evt <= '0;
    debug_entry <= 1'b0;
    @(posedge pclk);
  endtask : ev
  task automatic strobe(input int s);
    @(posedge pclk);
    case (s)
      0: exception_return_instr <= 1'b1;
      1: chained_return_instr <= 1'b1;
      default: prologue_req <= 1'b1;
    endcase
    @(posedge pclk);
    exception_return_instr <= 1'b0;
    chained_return_instr <= 1'b0;
    prologue_req <= 1'b0;
    @(posedge pclk);
  endtask : strobe
  task t_regs;
    rchk("ictl_rst", 12'h000, 32'h0);
    rchk("srs_rst", 12'h004, 32'h04000000);
    rchk("lvl_rst", 12'h008, 32'h00400004);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h000, 32'hffffffff);
    rchk("ictl_mask", 12'h000, 32'h007fe3e0);
    chk("prefetch_on", {31'h0, vector_prefetch_enable}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    @(posedge pclk);
    chk("prefetch_off", {31'h0, vector_prefetch_enable}, 32'h0);
    apb(1'b1, 12'h004, 32'hffff1c7f);
    rchk("srs_ro", 12'h004, 32'h04001040);
    chk("prev_sel", {28'h0, prev_set_sel}, 32'h1);
    strobe(0);
    chk("boot_ret", {28'h0, gpr_bank_sel}, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    strobe(0);
    chk("sw_css", {28'h0, gpr_bank_sel}, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    strobe(0);
  endtask : t_regs
  task t_spacing;
    logic [4:0] c [6];
    logic [9:0] b [6];
    // Only the six defined spacing codes are written in this task
    c = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    b = '{10'h000, 10'h020, 10'h040, 10'h080, 10'h100, 10'h200};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h000, {22'h0, c[i], 5'h0});
      repeat (2) @(posedge pclk);
      chk("spacing", {22'h0, vector_spacing_bytes}, {22'h0, b[i]});
    end
  endtask : t_spacing
  task t_prologue;
    logic [4:0] f [4];
    logic [3:0] ks, ap;
    logic [6:0] eb;
    f = '{5'h02, 5'h05, 5'h1f, 5'h07};
    ks = 4'b0101;
    ap = 4'b0111;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, {11'h0, f[i], 1'b0, ap[i], ks[i], 13'h0});
      strobe(2);
      eb = (f[i] < 5'h04) ? 7'h0c : {f[i], 2'b00};
      chk("prologue", {23'h0, copy_stack_from_prev, prologue_taken, stack_decrement_bytes},
          {23'h0, ap[i] & ~ks[i], ap[i], ap[i] ? eb : 7'h0});
    end
  endtask : t_prologue
  task t_chain;
    apb(1'b1, 12'h008, 32'h12);
    apb(1'b1, 12'h000, 32'h00200000);
    strobe(1);
    rchk("keep_lvl", 12'h008, 32'h12);
    apb(1'b1, 12'h000, 32'h00208000);
    strobe(1);
    chk("chain_on", {31'h0, chain_taken}, 32'h1);
    rchk("clr_lvl", 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    strobe(1);
    chk("chain_off", {31'h0, chain_taken}, 32'h0);
  endtask : t_chain
  task t_sets;
    eic.send(4'h1);
    vector_int_flag <= 1'b1;
    external_ctrl_mode_flag <= 1'b1;
    ev(1'b1, isc_pkg::ISC_EXC_GENERAL, 1'b0);
    rchk("eic_entry", 12'h004, 32'h04040001);
    chk("bank", {28'h0, gpr_bank_sel}, 32'h1);
    apb(1'b1, 12'h008, 32'h4);
    strobe(0);
    chk("erl_ret", {28'h0, gpr_bank_sel}, 32'h1);
    apb(1'b1, 12'h008, 32'h0);
    strobe(0);
    chk("ret", {28'h0, gpr_bank_sel}, 32'h0);
    eic.send(4'h0);
    // Plain exception in external mode must still take the exception set
    apb(1'b1, 12'h004, 32'h1040);
    ev(1'b0, isc_pkg::ISC_EXC_GENERAL, 1'b0);
    rchk("exc_entry", 12'h004, 32'h04001001);
    apb(1'b1, 12'h008, 32'h0);
    strobe(0);
    vector_int_flag <= 1'b0;
    apb(1'b1, 12'h004, 32'h1000);
    ev(1'b1, isc_pkg::ISC_EXC_GENERAL, 1'b0);
    chk("nonvec", {28'h0, gpr_bank_sel}, 32'h1);
    rchk("exl", 12'h008, 32'h2);
    apb(1'b1, 12'h004, 32'h0);
    ev(1'b0, isc_pkg::ISC_EXC_GENERAL, 1'b0);
    chk("at_exl", {28'h0, gpr_bank_sel}, 32'h1);
    for (int k = 1; k < 5; k++) begin
      apb(1'b1, 12'h008, 32'h0);
      ev(1'b0, isc_pkg::isc_exc_kind_e'(k), 1'b0);
      chk("erl_kind", {27'h0, gpr_bank_sel, error_level_flag}, 32'h3);
    end
    apb(1'b1, 12'h008, 32'h0);
    ev(1'b0, isc_pkg::ISC_EXC_GENERAL, 1'b1);
    chk("debug", {28'h0, gpr_bank_sel}, 32'h1);
  endtask : t_sets
  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("rst_bank", {28'h0, gpr_bank_sel}, 32'h0);
    rchk("rst_lvl", 12'h008, 32'h00400004);
    rchk("rst_srs", 12'h004, 32'h04000000);
  endtask : t_reset
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    exc_evt = '0;
    debug_entry = 1'b0;
    vector_int_flag = 1'b0;
    external_ctrl_mode_flag = 1'b0;
    exception_return_instr = 1'b0;
    chained_return_instr = 1'b0;
    prologue_req = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_spacing();
    t_prologue();
    t_chain();
    t_sets();
    t_reset();
    test_done();
  end
endmodule : tb_top
